/* dv/sbd_core_properties.sv */
`timescale 1ns/1ps
module sbd_core_checker #(
  parameter logic [15:0] VECTOR_ADDR = 16'hFFF0
) (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  // Inputs of the core
  input wire logic exec_start_in,
  input wire logic [7:0] opcode_in,
  input wire logic [7:0] branch_offset_in,
  input wire logic [15:0] pc_in,
  input wire logic negative_flag_in,
  input wire logic overflow_flag_in,
  input wire logic debug_request_in,
  // Outputs of the core
  input wire logic mem_rd_out,
  input wire logic [15:0] mem_addr_out,
  input wire sbd_pkg::sbd_cyc_type cycle_type_out,
  input wire logic done_out,
  input wire logic busy_out,
  input wire logic branch_taken_out,
  input wire logic [15:0] pc_out,
  input wire logic background_debug_mode_out,
  input wire logic [15:0] saved_return_pointer_out,
  input wire logic refill_out,
  input wire logic ccr_write_out
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_b_in);
  logic br_go;
  logic dbg_go;
  logic lose;
  logic [15:0] br_exp;
  // Request wins over an issued opcode
  assign br_go = !busy_out && !debug_request_in && exec_start_in && opcode_in == 8'h2C;
  assign dbg_go = !busy_out && (debug_request_in || (exec_start_in && opcode_in == 8'h00));
  assign lose = negative_flag_in ^ overflow_flag_in;
  assign br_exp = pc_in + 16'h0002 + (lose ? 16'h0000 : {{8{branch_offset_in[7]}}, branch_offset_in});
  sequence s_fetch;
    mem_rd_out && cycle_type_out == sbd_pkg::SBD_CYC_PROG;
  endsequence
  sequence s_vector;
    mem_rd_out && mem_addr_out == VECTOR_ADDR && cycle_type_out == sbd_pkg::SBD_CYC_VECTOR && background_debug_mode_out;
  endsequence
  a_flags_untouched: assert property (ccr_write_out == 1'b0)
    else $error("flag write seen");
  a_branch_decision: assert property (br_go |=> branch_taken_out == !$past(lose))
    else $error("branch decision wrong");
  a_branch_target: assert property (br_go |=> pc_out == $past(br_exp))
    else $error("branch target wrong");
  a_fetch_target: assert property (br_go && !lose |=> mem_addr_out == $past(br_exp))
    else $error("taken branch fetch address wrong");
  a_taken_fetches: assert property (br_go && !lose |=> s_fetch [*3] ##1 done_out && !busy_out)
    else $error("taken branch fetch count wrong");
  a_skip_fetch: assert property (br_go && lose |=> mem_rd_out && mem_addr_out == $past(pc_in) + 16'h0002
    ##1 done_out)
    else $error("untaken branch fetch wrong");
  a_entry_vector: assert property (dbg_go |=> s_vector ##1 cycle_type_out == sbd_pkg::SBD_CYC_FREE
    ##1 s_fetch [*3])
    else $error("entry sequence wrong");
  a_pointer_saved: assert property (dbg_go |=> saved_return_pointer_out == $past(pc_in))
    else $error("return pointer not saved");
  a_exit_refill: assert property (refill_out |-> mem_rd_out && pc_out == mem_addr_out
    && !background_debug_mode_out ##1 mem_rd_out [*2] ##1 done_out)
    else $error("exit refill wrong");
endmodule : sbd_core_checker

bind sbd_core sbd_core_checker #(.VECTOR_ADDR(VECTOR_ADDR)) i_sbd_core_checker (.*);

/* dv/sbd_mem_model.sv */
`timescale 1ns/1ps
module sbd_mem_model #(
  parameter logic [15:0] ENTRY_ADDR = 16'h1234,
  parameter logic [15:0] VECTOR_ADDR = 16'hFFF0,
  parameter logic [15:0] VECTOR_DATA = 16'h8000
) (
  // Clock
  input wire logic sys_clk_in,
  // Read port of the core
  input wire logic mem_rd_out,
  input wire logic [15:0] mem_addr_out,
  output logic [15:0] mem_rdata_in = 16'h0F0F
);
  // Idle bus toggles so stale data never looks valid
  always_ff @(posedge sys_clk_in) begin
    if (mem_rd_out) begin
      mem_rdata_in <= (mem_addr_out == ENTRY_ADDR) ? 16'h0000 :
        (mem_addr_out == VECTOR_ADDR) ? VECTOR_DATA : {mem_addr_out[7:0], 8'hA5};
    end else begin
      mem_rdata_in <= ~mem_rdata_in;
    end
  end
endmodule : sbd_mem_model

/* dv/signed_branch_and_debug_entry_tb_top.sv */
`timescale 1ns/1ps
module signed_branch_and_debug_entry_tb_top;
  localparam logic [15:0] ENTRY_ADDR = 16'h1234;
  logic sys_clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic exec_start_in = 1'b0;
  logic [7:0] opcode_in = 8'h00;
  logic [7:0] branch_offset_in = 8'h00;
  logic [15:0] pc_in = 16'h0000;
  logic negative_flag_in = 1'b0;
  logic overflow_flag_in = 1'b0;
  logic debug_request_in = 1'b0;
  logic debug_enable_in = 1'b0;
  logic debug_exit_in = 1'b0;
  logic [15:0] mem_rdata_in;
  logic mem_rd_out, busy_out, done_out, branch_taken_out, background_debug_mode_out, refill_out, ccr_write_out;
  logic [15:0] mem_addr_out, pc_out, saved_return_pointer_out;
  sbd_pkg::sbd_cyc_type cycle_type_out;
  logic [23:0] tbl [6] = '{24'h050310, 24'h030510, 24'h807FF0, 24'h7F8080, 24'hF0F07F, 24'hFE0200};
  int failures = 0;
  int cmp_count = 0;

  always #5 sys_clk_in = ~sys_clk_in;

  sbd_core i_sbd_core (.*);
  sbd_mem_model #(.ENTRY_ADDR(ENTRY_ADDR)) i_sbd_mem_model (.*);

  task end_of_test();
    $display("Checks %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_of_test

  task chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task pulse(input logic ex, input logic req);
    @(posedge sys_clk_in);
    #1;
    exec_start_in = ex;
    debug_request_in = req;
    @(posedge sys_clk_in);
    #1;
    exec_start_in = 1'b0;
    debug_request_in = 1'b0;
  endtask : pulse

  task wait_done();
    int n;
    n = 0;
    while (done_out !== 1'b1 && n < 60) begin
      @(posedge sys_clk_in);
      #1;
      n++;
    end
    chk("done", {15'h0, done_out}, 16'h0001);
  endtask : wait_done

  // Flags come from a real signed compare of r against m
  task t_branch(input logic [7:0] r, input logic [7:0] m, input logic [7:0] off);
    logic [7:0] d;
    logic tk;
    d = r - m;
    tk = $signed(r) >= $signed(m);
    opcode_in = 8'h2C;
    pc_in = 16'h4000;
    branch_offset_in = off;
    negative_flag_in = d[7];
    overflow_flag_in = (r[7] != m[7]) && (d[7] != r[7]);
    pulse(1'b1, 1'b0);
    wait_done();
    chk("taken", {15'h0, branch_taken_out}, {15'h0, tk});
    chk("branch_pc", pc_out, tk ? 16'h4002 + {{8{off[7]}}, off} : 16'h4002);
  endtask : t_branch

  task t_debug(input logic ex, input logic req, input logic en, input logic [15:0] pc, input logic [15:0] exp_pc);
    opcode_in = 8'h00;
    pc_in = pc;
    debug_enable_in = en;
    pulse(ex, req);
    chk("debug_mode", {15'h0, background_debug_mode_out}, 16'h0001);
    chk("saved_ptr", saved_return_pointer_out, pc);
    if (en) begin
      repeat (10) @(posedge sys_clk_in);
      #1;
      chk("active", {15'h0, background_debug_mode_out}, 16'h0001);
      // Issue while busy must be ignored
      opcode_in = 8'h2C;
      pulse(1'b1, 1'b0);
      debug_exit_in = 1'b1;
      @(posedge sys_clk_in);
      #1;
      debug_exit_in = 1'b0;
    end
    wait_done();
    chk("resume_pc", pc_out, exp_pc);
    chk("debug_off", {15'h0, background_debug_mode_out}, 16'h0000);
  endtask : t_debug

  initial begin
    repeat (5) @(posedge sys_clk_in);
    #1;
    rst_b_in = 1'b1;
    for (int i = 0; i < 6; i++) begin
      t_branch(tbl[i][23:16], tbl[i][15:8], tbl[i][7:0]);
    end
    t_debug(1'b1, 1'b0, 1'b1, ENTRY_ADDR, ENTRY_ADDR + 16'h0001);
    t_debug(1'b0, 1'b1, 1'b1, 16'h2000, 16'h2000);
    t_debug(1'b1, 1'b1, 1'b0, ENTRY_ADDR, ENTRY_ADDR);
    t_debug(1'b1, 1'b0, 1'b0, ENTRY_ADDR, ENTRY_ADDR + 16'h0001);
    end_of_test();
  end

  initial begin
    #50000;
    failures++;
    end_of_test();
  end
endmodule : signed_branch_and_debug_entry_tb_top

/* inc/sbd_defs.svh */
`ifndef SBD_DEFS_SVH
`define SBD_DEFS_SVH

// Opcodes handled by this slice
`define SBD_OP_BRANCH_GE 8'h2C
`define SBD_OP_DEBUG_ENTRY 8'h00

// Address step from a branch opcode to the following instruction
`define SBD_BRANCH_LEN 16'h0002
// Step between successive program fetches (one word each)
`define SBD_FETCH_STEP 16'h0002
// Program fetches after a taken branch and on debug entry or exit, minus one
`define SBD_PFETCH_LAST 2'h2

// Reset values
`define SBD_RST_ADDR 16'h0000
`define SBD_RST_CNT 2'h0

`endif

/* inc/sbd_pkg.sv */
package sbd_pkg;

  typedef enum logic [3:0] {
    SBD_IDLE = 4'h0,
    SBD_BR_FETCH = 4'h1,
    SBD_DBG_VECTOR = 4'h2,
    SBD_DBG_FREE = 4'h3,
    SBD_DBG_FETCH = 4'h4,
    SBD_DBG_CHECK_RD = 4'h5,
    SBD_DBG_CHECK = 4'h6,
    SBD_DBG_ACTIVE = 4'h7,
    SBD_DBG_REFILL = 4'h8
  } sbd_state_type;

  // Bus cycle kind shown for every clock
  typedef enum logic [1:0] {
    SBD_CYC_NONE = 2'h0,
    SBD_CYC_PROG = 2'h1,
    SBD_CYC_VECTOR = 2'h2,
    SBD_CYC_FREE = 2'h3
  } sbd_cyc_type;

endpackage : sbd_pkg

/* logic/sbd_branch_unit.sv */
`timescale 1ns/1ps
`include "sbd_defs.svh"

module sbd_branch_unit (
  // Instruction context
  input wire logic [15:0] pc_in,
  input wire logic [7:0] branch_offset_in,
  // Condition flags
  input wire logic negative_flag_in,
  input wire logic overflow_flag_in,
  // Decision
  output logic taken_out,
  output logic [15:0] target_out,
  output logic [15:0] next_out
);

  // N xor V is the sign of the true difference, so it holds for register-memory
  // compares and for B-minus-A after the accumulator compare alike
  assign taken_out = ~(negative_flag_in ^ overflow_flag_in);

  assign next_out = pc_in + `SBD_BRANCH_LEN;
  assign target_out = next_out + {{8{branch_offset_in[7]}}, branch_offset_in};

endmodule : sbd_branch_unit

/* logic/sbd_core.sv */
`timescale 1ns/1ps
`include "sbd_defs.svh"

module sbd_core #(
  parameter logic [15:0] VECTOR_ADDR = 16'hFFF0
) (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  // Instruction issue
  input wire logic exec_start_in,
  input wire logic [7:0] opcode_in,
  input wire logic [7:0] branch_offset_in,
  input wire logic [15:0] pc_in,
  input wire logic negative_flag_in,
  input wire logic overflow_flag_in,
  // Debug control from the serial command logic
  input wire logic debug_request_in,
  input wire logic debug_enable_in,
  input wire logic debug_exit_in,
  // Program memory
  input wire logic [15:0] mem_rdata_in,
  output logic mem_rd_out,
  output logic [15:0] mem_addr_out,
  output sbd_pkg::sbd_cyc_type cycle_type_out,
  // Status
  output logic busy_out,
  output logic done_out,
  output logic branch_taken_out,
  output logic [15:0] pc_out,
  output logic background_debug_mode_out,
  output logic [15:0] saved_return_pointer_out,
  output logic refill_out,
  output logic ccr_write_out
);

  logic br_taken;
  logic [15:0] br_target;
  logic [15:0] br_next;

  sbd_branch_unit u_branch (
    .pc_in(pc_in),
    .branch_offset_in(branch_offset_in),
    .negative_flag_in(negative_flag_in),
    .overflow_flag_in(overflow_flag_in),
    .taken_out(br_taken),
    .target_out(br_target),
    .next_out(br_next)
  );

  sbd_pkg::sbd_state_type state_r, state_nxt;
  logic [1:0] cnt_r, cnt_nxt;
  logic [15:0] resume_r, resume_nxt;
  logic from_request_r, from_request_nxt;
  logic mem_rd_r, mem_rd_nxt;
  logic [15:0] mem_addr_r, mem_addr_nxt;
  sbd_pkg::sbd_cyc_type cyc_r, cyc_nxt;
  logic busy_r, busy_nxt;
  logic done_r, done_nxt;
  logic taken_r, taken_nxt;
  logic [15:0] pc_r, pc_nxt;
  logic dbg_r, dbg_nxt;
  logic [15:0] ptr_r, ptr_nxt;
  logic refill_r, refill_nxt;
  logic ccr_write_r;
  logic start_branch;
  logic start_debug;

  assign start_branch = exec_start_in && (opcode_in == `SBD_OP_BRANCH_GE);
  // A pending request wins over a branch issued in the same cycle
  assign start_debug = debug_request_in || (exec_start_in && (opcode_in == `SBD_OP_DEBUG_ENTRY));

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    resume_nxt = resume_r;
    from_request_nxt = from_request_r;
    mem_rd_nxt = 1'b0;
    mem_addr_nxt = mem_addr_r;
    cyc_nxt = sbd_pkg::SBD_CYC_NONE;
    busy_nxt = busy_r;
    done_nxt = 1'b0;
    taken_nxt = taken_r;
    pc_nxt = pc_r;
    dbg_nxt = dbg_r;
    ptr_nxt = ptr_r;
    refill_nxt = 1'b0;
    case (state_r)
      sbd_pkg::SBD_IDLE: begin
        if (start_debug) begin
          // No stack traffic: straight to the vector read
          ptr_nxt = pc_in;
          from_request_nxt = debug_request_in;
          dbg_nxt = 1'b1;
          state_nxt = sbd_pkg::SBD_DBG_VECTOR;
          mem_rd_nxt = 1'b1;
          mem_addr_nxt = VECTOR_ADDR;
          cyc_nxt = sbd_pkg::SBD_CYC_VECTOR;
          busy_nxt = 1'b1;
        end else if (start_branch) begin
          taken_nxt = br_taken;
          state_nxt = sbd_pkg::SBD_BR_FETCH;
          cnt_nxt = br_taken ? `SBD_PFETCH_LAST : `SBD_RST_CNT;
          mem_rd_nxt = 1'b1;
          mem_addr_nxt = br_taken ? br_target : br_next;
          pc_nxt = br_taken ? br_target : br_next;
          cyc_nxt = sbd_pkg::SBD_CYC_PROG;
          busy_nxt = 1'b1;
        end
      end
      sbd_pkg::SBD_BR_FETCH: begin
        if (cnt_r == `SBD_RST_CNT) begin
          state_nxt = sbd_pkg::SBD_IDLE;
          busy_nxt = 1'b0;
          done_nxt = 1'b1;
        end else begin
          cnt_nxt = cnt_r - 2'h1;
          mem_rd_nxt = 1'b1;
          mem_addr_nxt = mem_addr_r + `SBD_FETCH_STEP;
          cyc_nxt = sbd_pkg::SBD_CYC_PROG;
        end
      end
      sbd_pkg::SBD_DBG_VECTOR: begin
        state_nxt = sbd_pkg::SBD_DBG_FREE;
        cyc_nxt = sbd_pkg::SBD_CYC_FREE;
      end
      sbd_pkg::SBD_DBG_FREE: begin
        // Vector word arrives one cycle after its read
        state_nxt = sbd_pkg::SBD_DBG_FETCH;
        cnt_nxt = `SBD_PFETCH_LAST;
        mem_rd_nxt = 1'b1;
        mem_addr_nxt = mem_rdata_in;
        cyc_nxt = sbd_pkg::SBD_CYC_PROG;
      end
      sbd_pkg::SBD_DBG_FETCH: begin
        if (cnt_r == `SBD_RST_CNT) begin
          state_nxt = sbd_pkg::SBD_DBG_CHECK_RD;
          mem_rd_nxt = 1'b1;
          mem_addr_nxt = ptr_r;
        end else begin
          cnt_nxt = cnt_r - 2'h1;
          mem_rd_nxt = 1'b1;
          mem_addr_nxt = mem_addr_r + `SBD_FETCH_STEP;
          cyc_nxt = sbd_pkg::SBD_CYC_PROG;
        end
      end
      sbd_pkg::SBD_DBG_CHECK_RD: begin
        state_nxt = sbd_pkg::SBD_DBG_CHECK;
      end
      sbd_pkg::SBD_DBG_CHECK: begin
        // Unincremented copy keeps a colliding request from skipping an instruction
        resume_nxt = ptr_r;
        if (mem_rdata_in[7:0] == `SBD_OP_DEBUG_ENTRY) begin
          ptr_nxt = ptr_r + 16'h0001;
        end
        state_nxt = sbd_pkg::SBD_DBG_ACTIVE;
      end
      sbd_pkg::SBD_DBG_ACTIVE: begin
        // Serial commands run here; only a host exit or a disabled mode leaves
        if (debug_exit_in || !debug_enable_in) begin
          dbg_nxt = 1'b0;
          state_nxt = sbd_pkg::SBD_DBG_REFILL;
          cnt_nxt = `SBD_PFETCH_LAST;
          mem_rd_nxt = 1'b1;
          mem_addr_nxt = from_request_r ? resume_r : ptr_r;
          pc_nxt = from_request_r ? resume_r : ptr_r;
          cyc_nxt = sbd_pkg::SBD_CYC_PROG;
          refill_nxt = 1'b1;
        end
      end
      sbd_pkg::SBD_DBG_REFILL: begin
        if (cnt_r == `SBD_RST_CNT) begin
          state_nxt = sbd_pkg::SBD_IDLE;
          busy_nxt = 1'b0;
          done_nxt = 1'b1;
        end else begin
          cnt_nxt = cnt_r - 2'h1;
          mem_rd_nxt = 1'b1;
          mem_addr_nxt = mem_addr_r + `SBD_FETCH_STEP;
          cyc_nxt = sbd_pkg::SBD_CYC_PROG;
        end
      end
      default: begin
        state_nxt = sbd_pkg::SBD_IDLE;
        busy_nxt = 1'b0;
        dbg_nxt = 1'b0;
      end
    endcase
  end

  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_r <= sbd_pkg::SBD_IDLE;
      cnt_r <= `SBD_RST_CNT;
      resume_r <= `SBD_RST_ADDR;
      from_request_r <= 1'b0;
      mem_rd_r <= 1'b0;
      mem_addr_r <= `SBD_RST_ADDR;
      cyc_r <= sbd_pkg::SBD_CYC_NONE;
      busy_r <= 1'b0;
      done_r <= 1'b0;
      taken_r <= 1'b0;
      pc_r <= `SBD_RST_ADDR;
      dbg_r <= 1'b0;
      ptr_r <= `SBD_RST_ADDR;
      refill_r <= 1'b0;
      ccr_write_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      resume_r <= resume_nxt;
      from_request_r <= from_request_nxt;
      mem_rd_r <= mem_rd_nxt;
      mem_addr_r <= mem_addr_nxt;
      cyc_r <= cyc_nxt;
      busy_r <= busy_nxt;
      done_r <= done_nxt;
      taken_r <= taken_nxt;
      pc_r <= pc_nxt;
      dbg_r <= dbg_nxt;
      ptr_r <= ptr_nxt;
      refill_r <= refill_nxt;
      // Flags pass through untouched for both instructions
      ccr_write_r <= 1'b0;
    end
  end

  assign mem_rd_out = mem_rd_r;
  assign mem_addr_out = mem_addr_r;
  assign cycle_type_out = cyc_r;
  assign busy_out = busy_r;
  assign done_out = done_r;
  assign branch_taken_out = taken_r;
  assign pc_out = pc_r;
  assign background_debug_mode_out = dbg_r;
  assign saved_return_pointer_out = ptr_r;
  assign refill_out = refill_r;
  assign ccr_write_out = ccr_write_r;

endmodule : sbd_core
